// [shared/hmc_pkg.sv]
package hmc_pkg;

   // Register port widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int EXP_W = 5;

   // Register offsets
   localparam logic [11:0] ADDR_STATUS = 12'h00E;
   localparam logic [11:0] ADDR_FLAG = 12'h013;
   localparam logic [11:0] ADDR_MASK = 12'h019;
   localparam logic [11:0] ADDR_EXIT_CTL = 12'h52C;
   localparam logic [11:0] ADDR_WINDOW = 12'h52E;
   localparam logic [11:0] ADDR_IGNORE = 12'h52F;
   localparam logic [11:0] ADDR_FORCE = 12'h535;
   localparam logic [11:0] ADDR_HIST_VALID = 12'h53F;
   localparam logic [11:0] ADDR_EXIT_BW = 12'h59B;

   // Field positions
   localparam int BIT_STATUS = 5;
   localparam int BIT_FLAG = 5;
   localparam int BIT_MASK = 5;
   localparam int BIT_RAMP_BYPASS = 3;
   localparam int BIT_BW_CHOICE = 4;
   localparam int BIT_FORCE = 0;
   localparam int BIT_HIST_VALID = 1;
   localparam int BIT_BW_FORCE = 6;

   // Reset values
   localparam logic RST_MASK = 1'h0;
   localparam logic RST_RAMP_BYPASS = 1'h0;
   localparam logic RST_BW_CHOICE = 1'h0;
   localparam logic RST_BW_FORCE = 1'h1;
   localparam logic RST_FORCE = 1'h0;
   localparam logic [4:0] RST_WINDOW = 5'h00;
   localparam logic [4:0] RST_IGNORE = 5'h00;

   // History time base: one unit is 268 ns, the clock period is 50 ns
   localparam int UNIT_NS = 268;
   localparam int CLK_NS = 50;
   localparam int NS_ACC_W = 9;
   localparam logic [NS_ACC_W-1:0] UNIT_NS_V = NS_ACC_W'(UNIT_NS);
   localparam logic [NS_ACC_W-1:0] CLK_NS_V = NS_ACC_W'(CLK_NS);
   localparam int UNIT_CNT_W = 33;

   // Exit bandwidth codes
   localparam logic [1:0] BW_NORMAL = 2'h0;
   localparam logic [1:0] BW_FASTLOCK = 2'h1;
   localparam logic [1:0] BW_HOLD_EXIT = 2'h2;

   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_RETAIN,
      ST_EXIT
   } hmc_mode_t;

endpackage

// [rtl/hmc_history.sv]
`timescale 1ns/1ps
`default_nettype none
module hmc_history (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Control
   input wire logic accumulate,
   input wire logic [hmc_pkg::EXP_W-1:0] window_exponent,
   input wire logic [hmc_pkg::EXP_W-1:0] ignore_exponent,
   // Status
   output logic history_valid
);

   logic [hmc_pkg::NS_ACC_W-1:0] ns_acc;
   logic [hmc_pkg::UNIT_CNT_W-1:0] units;
   logic [hmc_pkg::UNIT_CNT_W-1:0] need;
   logic [hmc_pkg::NS_ACC_W-1:0] next_ns;

   // Window plus ignore span, in 268 ns units
   always_comb begin
      need = ((hmc_pkg::UNIT_CNT_W'(1) << window_exponent) - hmc_pkg::UNIT_CNT_W'(1))
         + (hmc_pkg::UNIT_CNT_W'(1) << ignore_exponent);
      next_ns = ns_acc + hmc_pkg::CLK_NS_V;
   end

   // Fractional time base: 268 is not a multiple of 50, so carry the remainder
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ns_acc <= '0;
         units <= '0;
      end else if (ce && accumulate) begin
         if (next_ns >= hmc_pkg::UNIT_NS_V) begin
            ns_acc <= next_ns - hmc_pkg::UNIT_NS_V;
            if (units != '1) begin
               units <= units + hmc_pkg::UNIT_CNT_W'(1);
            end
         end else begin
            ns_acc <= next_ns;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         history_valid <= 1'b0;
      end else if (ce) begin
         history_valid <= (units >= need);
      end
   end

   property p_hist_pause;
      @(posedge clk) disable iff (!nrst)
      (!accumulate || !ce) |=> (units == $past(units)) && (ns_acc == $past(ns_acc));
   endproperty
   a_hist_pause: assert property (p_hist_pause) else $error("history moved while paused");

   property p_hist_valid;
      @(posedge clk) disable iff (!nrst)
      ce |=> (history_valid == ($past(units) >= $past(need)));
   endproperty
   a_hist_valid: assert property (p_hist_valid) else $error("history valid wrong");

endmodule // hmc_history
`default_nettype wire

// [rtl/hmc_exit.sv]
`timescale 1ns/1ps
`default_nettype none
module hmc_exit (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Sequencing
   input wire logic start,
   input wire logic abort,
   input wire logic done,
   // Exit controls
   input wire logic ramp_bypass,
   input wire logic bw_choice,
   input wire logic bw_force,
   // Exit path
   output logic exit_busy,
   output logic exit_ramp,
   output logic [1:0] exit_bw
);

   // Path is frozen at start so a control write mid-exit cannot glitch the loop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exit_busy <= 1'b0;
         exit_ramp <= 1'b0;
         exit_bw <= hmc_pkg::BW_NORMAL;
      end else if (ce) begin
         if (start) begin
            exit_busy <= 1'b1;
            exit_ramp <= !ramp_bypass;
            if (!ramp_bypass && !bw_choice) begin
               exit_bw <= hmc_pkg::BW_NORMAL;
            end else if (!ramp_bypass || bw_choice) begin
               exit_bw <= hmc_pkg::BW_NORMAL;
            end else if (bw_force) begin
               exit_bw <= hmc_pkg::BW_HOLD_EXIT;
            end else begin
               exit_bw <= hmc_pkg::BW_FASTLOCK;
            end
         end else if (done || abort) begin
            exit_busy <= 1'b0;
            exit_ramp <= 1'b0;
            exit_bw <= hmc_pkg::BW_NORMAL;
         end
      end
   end

   property p_ramp_path;
      @(posedge clk) disable iff (!nrst)
      (ce && start && !ramp_bypass) |=> exit_busy && exit_ramp && (exit_bw == hmc_pkg::BW_NORMAL);
   endproperty
   a_ramp_path: assert property (p_ramp_path) else $error("ramp exit not taken");

   property p_fast_bw;
      @(posedge clk) disable iff (!nrst)
      (ce && start && ramp_bypass && !bw_choice) |=> !exit_ramp
         && (exit_bw == (bw_force ? hmc_pkg::BW_HOLD_EXIT : hmc_pkg::BW_FASTLOCK));
   endproperty
   a_fast_bw: assert property (p_fast_bw) else $error("fastlock exit bandwidth wrong");

   property p_normal_bw;
      @(posedge clk) disable iff (!nrst)
      (ce && start && ramp_bypass && bw_choice) |=> !exit_ramp && (exit_bw == hmc_pkg::BW_NORMAL);
   endproperty
   a_normal_bw: assert property (p_normal_bw) else $error("normal exit bandwidth wrong");

endmodule // hmc_exit
`default_nettype wire

// [rtl/hmc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module hmc_top (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Register port
   input wire logic [hmc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [hmc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [hmc_pkg::DATA_W-1:0] reg_rdata,
   // Input monitors and loop
   input wire logic frequency_out_of_range_alarm,
   input wire logic signal_absent_alarm,
   input wire logic alt_input_valid,
   input wire logic pll_locked,
   input wire logic exit_done,
   // Mode
   output logic retention_active,
   output logic holdover_active,
   output logic freerun_active,
   output logic history_valid,
   // Exit path
   output logic exit_busy,
   output logic exit_ramp,
   output logic [1:0] exit_bw,
   // Averager settings
   output logic [hmc_pkg::EXP_W-1:0] window_exponent,
   output logic [hmc_pkg::EXP_W-1:0] ignore_exponent,
   // Interrupt
   output logic irq_output
);

   hmc_pkg::hmc_mode_t state;
   hmc_pkg::hmc_mode_t next_state;
   logic retention_sticky_flag;
   logic retention_irq_mask;
   logic exit_ramp_bypass;
   logic exit_bandwidth_choice;
   logic exit_bandwidth_force;
   logic force_retention;
   logic input_ok;
   logic input_lost;
   logic enter;
   logic exit_start;
   logic accumulate;
   logic flag_clear;
   logic [hmc_pkg::DATA_W-1:0] rd_value;

   always_comb begin
      input_ok = !frequency_out_of_range_alarm && !signal_absent_alarm;
      input_lost = !input_ok && !alt_input_valid;
      enter = force_retention || input_lost;
      exit_start = (state == hmc_pkg::ST_RETAIN) && !enter;
      accumulate = (state == hmc_pkg::ST_NORMAL) && input_ok && pll_locked;
   end

   always_comb begin
      next_state = state;
      case (state)
         hmc_pkg::ST_NORMAL: begin
            if (enter) begin
               next_state = hmc_pkg::ST_RETAIN;
            end
         end
         hmc_pkg::ST_RETAIN: begin
            if (!enter) begin
               next_state = hmc_pkg::ST_EXIT;
            end
         end
         hmc_pkg::ST_EXIT: begin
            if (enter) begin
               next_state = hmc_pkg::ST_RETAIN;
            end else if (exit_done) begin
               next_state = hmc_pkg::ST_NORMAL;
            end
         end
         default: begin
            next_state = hmc_pkg::ST_NORMAL;
         end
      endcase
   end

   // Mode outputs are registered from the same next value as the state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= hmc_pkg::ST_NORMAL;
         retention_active <= 1'b0;
         holdover_active <= 1'b0;
         freerun_active <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         retention_active <= (next_state == hmc_pkg::ST_RETAIN);
         holdover_active <= (next_state == hmc_pkg::ST_RETAIN) && history_valid;
         freerun_active <= (next_state == hmc_pkg::ST_RETAIN) && !history_valid;
      end
   end

   hmc_history u_history (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .accumulate(accumulate),
      .window_exponent(window_exponent),
      .ignore_exponent(ignore_exponent),
      .history_valid(history_valid)
   );

   hmc_exit u_exit (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .start(exit_start),
      .abort(enter),
      .done(exit_done),
      .ramp_bypass(exit_ramp_bypass),
      .bw_choice(exit_bandwidth_choice),
      .bw_force(exit_bandwidth_force),
      .exit_busy(exit_busy),
      .exit_ramp(exit_ramp),
      .exit_bw(exit_bw)
   );

   // Control registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         retention_irq_mask <= hmc_pkg::RST_MASK;
         exit_ramp_bypass <= hmc_pkg::RST_RAMP_BYPASS;
         exit_bandwidth_choice <= hmc_pkg::RST_BW_CHOICE;
         exit_bandwidth_force <= hmc_pkg::RST_BW_FORCE;
         force_retention <= hmc_pkg::RST_FORCE;
         window_exponent <= hmc_pkg::RST_WINDOW;
         ignore_exponent <= hmc_pkg::RST_IGNORE;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            hmc_pkg::ADDR_MASK: begin
               retention_irq_mask <= reg_wdata[hmc_pkg::BIT_MASK];
            end
            hmc_pkg::ADDR_EXIT_CTL: begin
               exit_ramp_bypass <= reg_wdata[hmc_pkg::BIT_RAMP_BYPASS];
               exit_bandwidth_choice <= reg_wdata[hmc_pkg::BIT_BW_CHOICE];
            end
            hmc_pkg::ADDR_WINDOW: begin
               window_exponent <= reg_wdata[hmc_pkg::EXP_W-1:0];
            end
            hmc_pkg::ADDR_IGNORE: begin
               ignore_exponent <= reg_wdata[hmc_pkg::EXP_W-1:0];
            end
            hmc_pkg::ADDR_FORCE: begin
               force_retention <= reg_wdata[hmc_pkg::BIT_FORCE];
            end
            hmc_pkg::ADDR_EXIT_BW: begin
               exit_bandwidth_force <= reg_wdata[hmc_pkg::BIT_BW_FORCE];
            end
            default: begin
            end
         endcase
      end
   end

   // A write of 0 or a read of the flag register asks to clear it
   always_comb begin
      flag_clear = (reg_addr == hmc_pkg::ADDR_FLAG)
         && ((reg_wr && !reg_wdata[hmc_pkg::BIT_FLAG]) || reg_rd);
   end

   // Status holding the flag set also makes a set win over a same-cycle clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         retention_sticky_flag <= 1'b0;
      end else if (ce) begin
         if (retention_active) begin
            retention_sticky_flag <= 1'b1;
         end else if (flag_clear) begin
            retention_sticky_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_output <= 1'b0;
      end else if (ce) begin
         irq_output <= retention_sticky_flag && !retention_irq_mask;
      end
   end

   always_comb begin
      rd_value = '0;
      case (reg_addr)
         hmc_pkg::ADDR_STATUS: rd_value[hmc_pkg::BIT_STATUS] = retention_active;
         hmc_pkg::ADDR_FLAG: rd_value[hmc_pkg::BIT_FLAG] = retention_sticky_flag;
         hmc_pkg::ADDR_MASK: rd_value[hmc_pkg::BIT_MASK] = retention_irq_mask;
         hmc_pkg::ADDR_EXIT_CTL: begin
            rd_value[hmc_pkg::BIT_RAMP_BYPASS] = exit_ramp_bypass;
            rd_value[hmc_pkg::BIT_BW_CHOICE] = exit_bandwidth_choice;
         end
         hmc_pkg::ADDR_WINDOW: rd_value[hmc_pkg::EXP_W-1:0] = window_exponent;
         hmc_pkg::ADDR_IGNORE: rd_value[hmc_pkg::EXP_W-1:0] = ignore_exponent;
         hmc_pkg::ADDR_FORCE: rd_value[hmc_pkg::BIT_FORCE] = force_retention;
         hmc_pkg::ADDR_HIST_VALID: rd_value[hmc_pkg::BIT_HIST_VALID] = history_valid;
         hmc_pkg::ADDR_EXIT_BW: rd_value[hmc_pkg::BIT_BW_FORCE] = exit_bandwidth_force;
         default: rd_value = '0;
      endcase
   end

   // Read data stand for one cycle only; unmapped offsets read zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_value : '0;
      end
   end

   sequence s_leave;
      ce && (state == hmc_pkg::ST_RETAIN) && !enter;
   endsequence

   sequence s_exiting;
      exit_busy && !retention_active && (state == hmc_pkg::ST_EXIT);
   endsequence

   property p_status_mode;
      @(posedge clk) disable iff (!nrst)
      retention_active == (state == hmc_pkg::ST_RETAIN);
   endproperty
   a_status_mode: assert property (p_status_mode) else $error("status disagrees with mode");

   property p_holdover_split;
      @(posedge clk) disable iff (!nrst)
      $past(ce) |-> (holdover_active == (retention_active && $past(history_valid)));
   endproperty
   a_holdover_split: assert property (p_holdover_split) else $error("holdover split wrong");

   property p_freerun_split;
      @(posedge clk) disable iff (!nrst)
      $past(ce) |-> (freerun_active == (retention_active && !$past(history_valid)));
   endproperty
   a_freerun_split: assert property (p_freerun_split) else $error("freerun split wrong");

   property p_flag_sets;
      @(posedge clk) disable iff (!nrst)
      (ce && retention_active) |=> retention_sticky_flag
         ##1 (retention_sticky_flag || !ce || !$past(retention_active));
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("sticky flag lost");

   property p_flag_clears;
      @(posedge clk) disable iff (!nrst)
      (ce && reg_wr && (reg_addr == hmc_pkg::ADDR_FLAG) && !reg_wdata[hmc_pkg::BIT_FLAG]
         && !retention_active) |=> !retention_sticky_flag;
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared");

   property p_irq_gate;
      @(posedge clk) disable iff (!nrst)
      ce |=> (irq_output == ($past(retention_sticky_flag) && !$past(retention_irq_mask)));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

   property p_force_enter;
      @(posedge clk) disable iff (!nrst)
      (ce && force_retention) |=> retention_active;
   endproperty
   a_force_enter: assert property (p_force_enter) else $error("force did not retain");

   property p_loss_enter;
      @(posedge clk) disable iff (!nrst)
      (ce && input_lost) |=> retention_active [*1] ##0 !exit_busy;
   endproperty
   a_loss_enter: assert property (p_loss_enter) else $error("input loss did not retain");

   property p_leave_exit;
      @(posedge clk) disable iff (!nrst)
      s_leave |=> s_exiting;
   endproperty
   a_leave_exit: assert property (p_leave_exit) else $error("exit path not started");

endmodule // hmc_top
`default_nettype wire

// [testbench/hmc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module hmc_top_bench;
   logic clk, nrst, ce, reg_wr, reg_rd, freq_alarm, absent_alarm, alt_valid, locked, exit_done;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic ret, hold, free, hist, busy, ramp, irq;
   logic [1:0] bw;
   logic [4:0] win, ign;
   int error_cnt = 0, n_tests = 0, cnt, k;
   // Behavioural register model: RW images plus mode state
   logic [7:0] mdl [logic [11:0]];
   logic m_ret = 0, m_flg = 0, m_hist = 0;
   logic [11:0] all_a [10] = '{12'h00E, 12'h013, 12'h019, 12'h52C, 12'h52E, 12'h52F,
                               12'h535, 12'h53F, 12'h59B, 12'h123};
   logic [11:0] rw_a [5] = '{12'h019, 12'h52C, 12'h52E, 12'h52F, 12'h59B};

   hmc_top u_hmc_top (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .frequency_out_of_range_alarm(freq_alarm), .signal_absent_alarm(absent_alarm),
      .alt_input_valid(alt_valid), .pll_locked(locked), .exit_done(exit_done),
      .retention_active(ret), .holdover_active(hold), .freerun_active(free),
      .history_valid(hist), .exit_busy(busy), .exit_ramp(ramp), .exit_bw(bw),
      .window_exponent(win), .ignore_exponent(ign), .irq_output(irq));

   always #25 clk = ~clk;

   function automatic logic [7:0] msk(input logic [11:0] a);
      case (a)
         12'h019: msk = 8'h20;
         12'h52C: msk = 8'h18;
         12'h52E, 12'h52F: msk = 8'h1F;
         12'h535: msk = 8'h01;
         12'h59B: msk = 8'h40;
         default: msk = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] exp_rd(input logic [11:0] a);
      case (a)
         12'h00E: exp_rd = {2'h0, m_ret, 5'h00};
         12'h013: exp_rd = {2'h0, m_flg, 5'h00};
         12'h53F: exp_rd = {6'h00, m_hist, 1'h0};
         default: exp_rd = mdl.exists(a) ? mdl[a] : 8'h00;
      endcase
   endfunction

   task automatic test_done();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (msk(a) != 8'h00) mdl[a] = v & msk(a);
      if (a == 12'h013 && !v[5] && !m_ret) m_flg = 0;
   endtask

   task automatic rd_chk(input logic [11:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp_rd(a));
      if (a == 12'h013 && !m_ret) m_flg = 0;
   endtask

   // Exit completes on the loop's report; a stuck exit ends the run
   task automatic finish_exit();
      @(posedge clk);
      exit_done <= 1'b1;
      @(posedge clk);
      exit_done <= 1'b0;
      // Poll between edges so the value seen is the settled one
      for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge clk);
      if (k == 20) begin
         chk(busy, 8'h00);
         test_done();
      end
      tick(1);
   endtask

   initial begin
      clk = 0; nrst = 0; ce = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
      freq_alarm = 0; absent_alarm = 0; alt_valid = 0; locked = 0; exit_done = 0;
      mdl[12'h019] = 8'h00; mdl[12'h52C] = 8'h00; mdl[12'h52E] = 8'h00;
      mdl[12'h52F] = 8'h00; mdl[12'h535] = 8'h00; mdl[12'h59B] = 8'h40;
      void'($urandom(28));
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      foreach (all_a[i]) rd_chk(all_a[i]);
      wr(12'h00E, 8'hFF);
      wr(12'h53F, 8'hFF);
      rd_chk(12'h00E);
      rd_chk(12'h53F);
      // A strobe while the enable is low must not be taken
      @(posedge clk);
      ce <= 1'b0;
      reg_addr <= 12'h019;
      reg_wdata <= 8'h20;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      ce <= 1'b1;
      rd_chk(12'h019);
      repeat (4) begin
         foreach (rw_a[i]) wr(rw_a[i], 8'($urandom));
         foreach (rw_a[i]) rd_chk(rw_a[i]);
         chk(win, mdl[12'h52E]);
         chk(ign, mdl[12'h52F]);
      end
      wr(12'h019, 8'h00);
      // Forced retention with no history gives freerun
      wr(12'h535, 8'h01);
      tick(3);
      m_ret = 1;
      m_flg = 1;
      chk({ret, hold, free}, 8'h05);
      tick(1);
      chk(irq, 8'h01);
      rd_chk(12'h00E);
      rd_chk(12'h53F);
      wr(12'h013, 8'h00);
      rd_chk(12'h013);
      wr(12'h019, 8'h20);
      tick(2);
      chk(irq, 8'h00);
      wr(12'h019, 8'h00);
      tick(2);
      chk(irq, 8'h01);
      wr(12'h535, 8'h00);
      m_ret = 0;
      tick(2);
      chk({ret, busy}, 8'h01);
      finish_exit();
      rd_chk(12'h00E);
      rd_chk(12'h013);
      tick(2);
      chk(irq, 8'h00);
      // History needs (2^3-1)+2^2 units of 268 ns while locked
      wr(12'h52E, 8'h03);
      wr(12'h52F, 8'h02);
      @(posedge clk);
      locked <= 1'b1;
      repeat (30) @(posedge clk);
      locked <= 1'b0;
      tick(1);
      chk(hist, 8'h00);
      tick(40);
      chk(hist, 8'h00);
      @(posedge clk);
      locked <= 1'b1;
      cnt = 0;
      while (hist !== 1'b1 && cnt < 80) begin
         @(negedge clk);
         cnt++;
      end
      k = (((1 << 3) - 1 + (1 << 2)) * 268 + 49) / 50 - 30;
      chk(8'(cnt >= k - 1 && cnt <= k + 3), 8'h01);
      if (cnt == 80) test_done();
      m_hist = 1;
      rd_chk(12'h53F);
      // Every exit path and bandwidth selection
      for (int i = 0; i < 8; i++) begin
         wr(12'h52C, {3'h0, i[1], i[0], 3'h0});
         wr(12'h59B, {1'h0, i[2], 6'h00});
         wr(12'h535, 8'h01);
         tick(3);
         chk({ret, hold, free}, 8'h06);
         wr(12'h535, 8'h00);
         tick(2);
         chk({busy, ramp}, {6'h00, 1'b1, !i[0]});
         chk(bw, !i[0] ? 8'h00 : i[1] ? 8'h00 : i[2] ? 8'h02 : 8'h01);
         if (i == 7) begin
            @(posedge clk);
            absent_alarm <= 1'b1;
            tick(2);
            chk({ret, busy}, 8'h02);
            @(posedge clk);
            absent_alarm <= 1'b0;
            tick(2);
            chk(busy, 8'h01);
         end
         finish_exit();
      end
      // Alarms enter holdover only without another valid input
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         alt_valid <= 1'b1;
         freq_alarm <= (j == 0);
         absent_alarm <= (j == 1);
         tick(3);
         chk(ret, 8'h00);
         @(posedge clk);
         alt_valid <= 1'b0;
         tick(3);
         m_ret = 1;
         m_flg = 1;
         chk({ret, hold, free}, 8'h06);
         rd_chk(12'h00E);
         @(posedge clk);
         freq_alarm <= 1'b0;
         absent_alarm <= 1'b0;
         tick(2);
         m_ret = 0;
         chk(busy, 8'h01);
         finish_exit();
      end
      // Writing 0 once the status has dropped clears the flag and the interrupt
      chk(irq, 8'h01);
      wr(12'h013, 8'h00);
      tick(2);
      chk(irq, 8'h00);
      rd_chk(12'h013);
      test_done();
   end
endmodule // hmc_top_bench
`default_nettype wire
